/* File: common/mmap_pkg.sv */
package mmap_pkg;

    // ----------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [7:0] IDX_CHIP_MODE = 8'h70;
    localparam logic [7:0] IDX_RSVD_LO = 8'h70;
    localparam logic [7:0] IDX_SOURCE_TARGET = 8'h80;
    localparam logic [7:0] IDX_ACCESS_KIND = 8'h81;
    localparam logic [7:0] IDX_USER_STATE = 8'h82;
    localparam logic [7:0] IDX_INT_MASKS = 8'h83;
    localparam logic [7:0] IDX_PC_HIGH = 8'h85;
    localparam logic [7:0] IDX_PC_MID = 8'h86;
    localparam logic [7:0] IDX_PC_LOW = 8'h87;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h00;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h01;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h02;

    // ----------------------------------------
    // Field positions and values
    // ----------------------------------------
    localparam int MODE_BIT = 7;
    localparam int USER_BIT = 7;
    localparam int XMASK_BIT = 6;
    localparam int IMASK_BIT = 4;
    localparam logic MODE_SPECIAL = 1'b0;
    localparam logic MODE_NORMAL = 1'b1;
    localparam logic [15:0] ERR_CLEAR_KEY = 16'hffff;
    localparam int STAT_VIOLATION = 0;
    localparam int STAT_ECC = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [3:0] INIT_NONE = 4'h0;
    localparam logic [3:0] INIT_CPU = 4'h1;
    localparam logic [3:0] INIT_ADC = 4'h3;
    localparam logic [3:0] TGT_NONE = 4'h0;
    localparam logic [3:0] TGT_REGS = 4'h1;
    localparam logic [3:0] TGT_RAM = 4'h2;
    localparam logic [3:0] TGT_EEPROM = 4'h3;
    localparam logic [3:0] TGT_PFLASH = 4'h4;
    localparam logic [3:0] ACC_OPCODE = 4'h1;
    localparam logic [3:0] ACC_VECTOR = 4'h2;
    localparam logic [3:0] ACC_LOAD = 4'h3;
    localparam logic [3:0] ACC_STORE = 4'h4;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_ILLEGAL = 4'h1;
    localparam logic [3:0] ERR_ECC = 4'h2;

    // ----------------------------------------
    // Global map bounds, 24-bit address space
    // ----------------------------------------
    localparam logic [23:0] REGS_LAST = 24'h000fff;
    localparam logic [23:0] RAM_FIRST = 24'h001000;
    localparam logic [23:0] RAM_LAST = 24'h00ffff;
    localparam logic [23:0] EEPROM_FIRST = 24'h100000;
    localparam logic [23:0] EEPROM_LAST = 24'h100fff;
    localparam logic [23:0] PFLASH_FIRST = 24'h800000;

    // Masters: 0 core, 1 debug, 2 converter
    typedef enum logic [1:0] {MST_CPU = 2'h0, MST_DBG = 2'h1, MST_ADC = 2'h2} mmap_master_e;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [3:0] access;
    } mmap_req_s;

    typedef struct packed {
        logic grant;
        logic error;
    } mmap_resp_s;

    typedef struct packed {
        logic valid;
        mmap_master_e master;
        logic [23:0] addr;
        logic store;
    } mmap_tsel_s;

    typedef struct packed {
        logic user;
        logic xMask;
        logic iMask;
        logic [23:0] pc;
    } mmap_cpu_s;

endpackage : mmap_pkg

/* File: verilog/mmap_memory_map_mode_control.sv */
`timescale 1ns/1ps

module mmap_memory_map_mode_control (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Chip pins and power state
    input wire logic modePin,
    input wire logic stopMode,
    // Masters
    input wire mmap_pkg::mmap_req_s [2:0] masterReq,
    output mmap_pkg::mmap_resp_s [2:0] masterResp,
    input wire mmap_pkg::mmap_cpu_s cpuState,
    output logic machineException,
    // Targets: registers, RAM, EEPROM, program flash
    output mmap_pkg::mmap_tsel_s [3:0] targetSel,
    input wire logic [3:0] eccError,
    // Chip mode and interrupt
    output logic modeSelect,
    output logic irq,
    // AXI4-Lite slave
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import mmap_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] boot;
        logic [1:0] modeSync;
        logic modeSelect;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic awHeld;
        logic [7:0] awIdx;
        logic awBad;
        logic wHeld;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] initiator;
        logic [3:0] target;
        logic [3:0] access;
        logic [3:0] errType;
        mmap_cpu_s cap;
        logic [1:0] status;
        logic [1:0] enable;
        logic irq;
        logic exception;
        mmap_resp_s [2:0] resp;
        mmap_tsel_s [3:0] tsel;
        mmap_master_e [3:0] lastMaster;
        logic [3:0][3:0] lastAccess;
    } mmap_state_s;

    mmap_state_s s;
    mmap_state_s n;

    // Fixed priority: debug first, then core, then converter
    localparam mmap_master_e PRIO [3] = '{MST_DBG, MST_CPU, MST_ADC};

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [3:0] decode(input logic [23:0] addr);
        logic [3:0] code;
        code = TGT_NONE;
        if (addr <= REGS_LAST) begin
            code = TGT_REGS;
        end else if (addr >= RAM_FIRST && addr <= RAM_LAST) begin
            code = TGT_RAM;
        end else if (addr >= EEPROM_FIRST && addr <= EEPROM_LAST) begin
            code = TGT_EEPROM;
        end else if (addr >= PFLASH_FIRST) begin
            code = TGT_PFLASH;
        end
        return code;
    endfunction : decode

    function automatic logic legal(input mmap_master_e m, input logic [3:0] tgt, input logic [3:0] acc);
        logic ok;
        ok = (tgt != TGT_NONE) && (acc >= ACC_OPCODE) && (acc <= ACC_STORE);
        // Nonvolatile arrays are programmed through their controller, never by a store
        if (acc == ACC_STORE && (tgt == TGT_EEPROM || tgt == TGT_PFLASH)) begin
            ok = 1'b0;
        end
        // Converter only stores results into RAM
        if (m == MST_ADC && !(acc == ACC_STORE && tgt == TGT_RAM)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : legal

    function automatic logic [3:0] initCode(input mmap_master_e m);
        logic [3:0] code;
        unique case (m)
            MST_CPU: code = INIT_CPU;
            MST_ADC: code = INIT_ADC;
            default: code = INIT_NONE;
        endcase
        return code;
    endfunction : initCode

    function automatic logic mapped(input logic [7:0] idx);
        return (idx >= IDX_RSVD_LO) || (idx <= IDX_IRQ_ENABLE);
    endfunction : mapped

    function automatic logic [7:0] readByte(input mmap_state_s st, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_CHIP_MODE: v[MODE_BIT] = st.modeSelect;
            IDX_SOURCE_TARGET: v = {st.initiator, st.target};
            IDX_ACCESS_KIND: v = {st.access, st.errType};
            IDX_USER_STATE: v[USER_BIT] = st.cap.user;
            IDX_INT_MASKS: begin
                v[XMASK_BIT] = st.cap.xMask;
                v[IMASK_BIT] = st.cap.iMask;
            end
            IDX_PC_HIGH: v = st.cap.pc[23:16];
            IDX_PC_MID: v = st.cap.pc[15:8];
            IDX_PC_LOW: v = st.cap.pc[7:0];
            IDX_IRQ_STATUS: v = {6'h00, st.status};
            IDX_IRQ_ENABLE: v = {6'h00, st.enable};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : readByte

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic doWrite;
    logic clearErr;
    logic [1:0] clearBits;
    logic vFound;
    logic eccFound;
    logic [3:0] vInit;
    logic [3:0] vTgt;
    logic [3:0] vAcc;
    logic [3:0] vType;
    logic [3:0] tgtCode [3];
    logic isLegal [3];
    logic taken;
    logic [7:0] arIdx;

    always_comb begin
        n = s;
        doWrite = 1'b0;
        clearErr = 1'b0;
        clearBits = 2'h0;
        vFound = 1'b0;
        eccFound = 1'b0;
        vInit = INIT_NONE;
        vTgt = TGT_NONE;
        vAcc = 4'h0;
        vType = ERR_NONE;
        taken = 1'b0;
        arIdx = araddr[9:2];
        for (int m = 0; m < 3; m++) begin
            tgtCode[m] = decode(masterReq[m].addr);
            isLegal[m] = legal(mmap_master_e'(m), tgtCode[m], masterReq[m].access);
        end

        // Mode pin synchroniser, caught once after reset release
        n.modeSync = {s.modeSync[0], modePin};
        if (s.boot != 2'h3) begin
            n.boot = s.boot + 2'h1;
            if (s.boot == 2'h2) begin
                n.modeSelect = s.modeSync[1];
            end
        end

        // AXI write: address and data taken in either order
        if (s.awready && awvalid) begin
            n.awHeld = 1'b1;
            n.awIdx = awaddr[9:2];
            n.awBad = (awaddr[11:10] != 2'h0);
        end
        if (s.wready && wvalid) begin
            n.wHeld = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        doWrite = s.awHeld && s.wHeld && !s.bvalid;
        if (doWrite) begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (!s.awBad && mapped(s.awIdx)) ? RESP_OKAY : RESP_SLVERR;
            if (!s.awBad) begin
                unique case (s.awIdx)
                    IDX_CHIP_MODE: begin
                        if (s.wstrb[0] && s.boot == 2'h3 && s.modeSelect == MODE_SPECIAL
                                && s.wdata[MODE_BIT] == MODE_NORMAL) begin
                            n.modeSelect = MODE_NORMAL;
                        end
                    end
                    IDX_SOURCE_TARGET, IDX_ACCESS_KIND: begin
                        clearErr = (s.wstrb[1:0] == 2'h3) && (s.wdata[15:0] == ERR_CLEAR_KEY);
                    end
                    IDX_IRQ_CLEAR: begin
                        clearBits = s.wdata[1:0] & {2{s.wstrb[0]}};
                    end
                    IDX_IRQ_ENABLE: begin
                        if (s.wstrb[0]) begin
                            n.enable = s.wdata[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        n.awready = !n.awHeld;
        n.wready = !n.wHeld;

        // AXI read: one word in flight
        if (s.arready && arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = (araddr[11:10] == 2'h0 && mapped(arIdx)) ? RESP_OKAY : RESP_SLVERR;
            n.rdata = (araddr[11:10] == 2'h0) ? {24'h000000, readByte(s, arIdx)} : 32'h00000000;
        end else if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;

        // Routing: each target picks one master, targets run in parallel
        for (int m = 0; m < 3; m++) begin
            n.resp[m] = '0;
        end
        for (int t = 0; t < 4; t++) begin
            n.tsel[t].valid = 1'b0;
        end
        if (!stopMode) begin
            for (int t = 0; t < 4; t++) begin
                taken = 1'b0;
                for (int p = 0; p < 3; p++) begin
                    if (!taken && masterReq[PRIO[p]].valid && !s.resp[PRIO[p]].grant && isLegal[PRIO[p]]
                            && tgtCode[PRIO[p]] == 4'(t + 1)) begin
                        taken = 1'b1;
                        n.resp[PRIO[p]].grant = 1'b1;
                        n.tsel[t].valid = 1'b1;
                        n.tsel[t].master = PRIO[p];
                        n.tsel[t].addr = masterReq[PRIO[p]].addr;
                        n.tsel[t].store = (masterReq[PRIO[p]].access == ACC_STORE);
                        n.lastMaster[t] = PRIO[p];
                        n.lastAccess[t] = masterReq[PRIO[p]].access;
                    end
                end
            end
            // Illegal requests are answered at once and never reach a target
            for (int m = 0; m < 3; m++) begin
                if (masterReq[m].valid && !s.resp[m].grant && !isLegal[m]) begin
                    n.resp[m].grant = 1'b1;
                    n.resp[m].error = 1'b1;
                end
            end
        end

        // Violation pick: ECC on last read first, then illegal requests
        for (int t = 0; t < 4; t++) begin
            if (!vFound && eccError[t] && s.lastAccess[t] != ACC_STORE
                    && initCode(s.lastMaster[t]) != INIT_NONE) begin
                vFound = 1'b1;
                eccFound = 1'b1;
                vInit = initCode(s.lastMaster[t]);
                vTgt = 4'(t + 1);
                vAcc = s.lastAccess[t];
                vType = ERR_ECC;
            end
        end
        for (int m = 0; m < 3; m++) begin
            if (!vFound && !stopMode && masterReq[m].valid && !s.resp[m].grant && !isLegal[m]
                    && initCode(mmap_master_e'(m)) != INIT_NONE) begin
                vFound = 1'b1;
                vInit = initCode(mmap_master_e'(m));
                vTgt = tgtCode[m];
                vAcc = masterReq[m].access;
                vType = ERR_ILLEGAL;
            end
        end

        // Error log: cleared first so a same-cycle violation still lands
        if (clearErr) begin
            n.initiator = INIT_NONE;
            n.target = TGT_NONE;
            n.access = 4'h0;
            n.errType = ERR_NONE;
        end
        if (vFound && n.errType == ERR_NONE) begin
            n.initiator = vInit;
            n.target = vTgt;
            n.access = vAcc;
            n.errType = vType;
            n.cap = cpuState;
        end
        n.exception = vFound;

        // Sticky status, set wins over clear
        n.status = s.status & ~clearBits;
        n.status[STAT_VIOLATION] = n.status[STAT_VIOLATION] | vFound;
        n.status[STAT_ECC] = n.status[STAT_ECC] | eccFound;
        n.irq = |(n.status & n.enable);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign masterResp = s.resp;
    assign machineException = s.exception;
    assign targetSel = s.tsel;
    assign modeSelect = s.modeSelect;
    assign irq = s.irq;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;

endmodule : mmap_memory_map_mode_control

/* File: dv/mmap_assertions.sv */
`timescale 1ns/1ps
module mmap_assertions
    import mmap_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Observed ports
    input wire logic modePin,
    input wire logic stopMode,
    input wire mmap_pkg::mmap_resp_s [2:0] masterResp,
    input wire logic machineException,
    input wire mmap_pkg::mmap_tsel_s [3:0] targetSel,
    input wire logic [3:0] eccError,
    input wire logic modeSelect,
    input wire logic rvalid,
    input wire logic [1:0] rresp,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Pin load lands on the third edge, so count edges since release
    logic [2:0] bootCnt;
    logic anyGrant;
    logic anyRoute;
    assign anyGrant = masterResp[0].grant | masterResp[1].grant | masterResp[2].grant;
    assign anyRoute = targetSel[0].valid | targetSel[1].valid | targetSel[2].valid | targetSel[3].valid;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bootCnt <= 3'h0;
        end else if (bootCnt != 3'h4) begin
            bootCnt <= bootCnt + 3'h1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_mode_load: assert property (bootCnt == 3'h3 |-> modeSelect == modePin)
        else $error("mode bit differs from pin after reset");
    chk_mode_boot: assert property (bootCnt < 3'h3 |-> !modeSelect)
        else $error("mode bit set before load");
    chk_mode_sticky: assert property (modeSelect |=> modeSelect)
        else $error("mode left normal operation");
    chk_stop_grant: assert property (stopMode |=> !anyGrant)
        else $error("grant during stop");
    chk_stop_route: assert property (stopMode |=> !anyRoute)
        else $error("target selected during stop");
    chk_core_exc: assert property (masterResp[0].grant && masterResp[0].error |-> machineException)
        else $error("refused core access without exception");
    chk_ecc_exc: assert property (|eccError |=> machineException)
        else $error("ECC fault without exception");
    chk_nvm_store: assert property (!((targetSel[2].valid && targetSel[2].store) ||
        (targetSel[3].valid && targetSel[3].store)))
        else $error("store routed to nonvolatile memory");
    chk_adc_path: assert property (masterResp[2].grant && !masterResp[2].error |->
        targetSel[1].valid && targetSel[1].master == MST_ADC && targetSel[1].store)
        else $error("converter grant without RAM route");
    chk_read_zero: assert property (rvalid && rresp == RESP_OKAY |-> rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    cover property (masterResp[0].grant && masterResp[0].error);
    cover property (|eccError);
    cover property (masterResp[2].grant && !masterResp[2].error);
endmodule : mmap_assertions

/* File: dv/mmap_target_model.sv */
`timescale 1ns/1ps
module mmap_target_model
    import mmap_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Target side
    input wire mmap_pkg::mmap_tsel_s [3:0] targetSel,
    input wire logic [3:0] failMask,
    output logic [3:0] eccError
);
    import mmap_pkg::*;
    // Only reads can carry a data fault; stores never report one
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            eccError <= 4'h0;
        end else begin
            for (int t = 0; t < 4; t++) begin
                eccError[t] <= targetSel[t].valid && !targetSel[t].store && failMask[t];
            end
        end
    end
endmodule : mmap_target_model

/* File: dv/mmap_memory_map_mode_control_tb_top.sv */
`timescale 1ns/1ps
module mmap_memory_map_mode_control_tb_top;
    import mmap_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic modePin = 1'b0;
    logic stopMode = 1'b0;
    mmap_req_s [2:0] masterReq = '0;
    mmap_resp_s [2:0] masterResp;
    mmap_cpu_s cpuState = '0;
    mmap_tsel_s [3:0] targetSel;
    logic machineException, modeSelect, irq;
    logic [3:0] eccError;
    logic [3:0] failMask = 4'h0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, e, x, e2, x2;
    logic [1:0] bresp, rresp, rs;
    int num_errors = 0;
    int checked = 0;
    int t0, t1;

    always #10 clock = ~clock;

    mmap_memory_map_mode_control dut (.clock(clock), .rstn(rstn), .modePin(modePin), .stopMode(stopMode),
        .masterReq(masterReq), .masterResp(masterResp), .cpuState(cpuState), .machineException(machineException),
        .targetSel(targetSel), .eccError(eccError), .modeSelect(modeSelect), .irq(irq), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    mmap_target_model partner (.clock(clock), .rstn(rstn), .targetSel(targetSel), .failMask(failMask),
        .eccError(eccError));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmpVal(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmpVal

    task automatic end_sim();
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic axiWr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        logic a, w, b;
        n = 0;
        @(posedge clock);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clock);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clock);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
            n++;
        end while (!b && n < 100);
        if (!b) cmpVal("bvalid", 32'h1, 32'h0);
    endtask : axiWr

    task automatic axiRd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic a, v;
        n = 0;
        @(posedge clock);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clock);
            a = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (a) arvalid <= 1'b0;
            if (v) rready <= 1'b0;
            n++;
        end while (!v && n < 100);
        if (!v) cmpVal("rvalid", 32'h1, 32'h0);
    endtask : axiRd

    task automatic wrChk(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] ex);
        logic [1:0] r;
        axiWr(idx, d, s, r);
        cmpVal("bresp", 32'(ex), 32'(r));
    endtask : wrChk

    task automatic rdChk(input logic [7:0] idx, input logic [31:0] ex);
        axiRd(idx, rd, rs);
        cmpVal("rdata", ex, rd);
        cmpVal("rresp", 32'(RESP_OKAY), 32'(rs));
    endtask : rdChk

    // Master request held until its grant, dropped on the following edge
    task automatic req(input int m, input logic [23:0] a, input logic [3:0] k, output logic err, output logic exc,
        output int t);
        t = 0;
        @(posedge clock);
        masterReq[m] <= '{1'b1, a, k};
        do begin
            @(negedge clock);
            t++;
        end while (masterResp[m].grant !== 1'b1 && t < 50);
        err = masterResp[m].error;
        exc = machineException;
        if (masterResp[m].grant !== 1'b1) cmpVal("grant", 32'h1, 32'h0);
        @(posedge clock);
        masterReq[m].valid <= 1'b0;
    endtask : req

    task automatic doReset(input logic pin);
        @(posedge clock);
        rstn <= 1'b0;
        modePin <= pin;
        repeat (3) @(posedge clock);
        cmpVal("modeInReset", 32'h0, 32'(modeSelect));
        rstn <= 1'b1;
        repeat (5) @(posedge clock);
    endtask : doReset

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    initial begin
        doReset(1'b0);
        cmpVal("modeSelect", 32'(MODE_SPECIAL), 32'(modeSelect));
        rdChk(IDX_SOURCE_TARGET, 32'h0);
        wrChk(IDX_CHIP_MODE, 32'hff, 4'h1, RESP_OKAY);
        rdChk(IDX_CHIP_MODE, 32'h80);
        wrChk(IDX_CHIP_MODE, 32'h0, 4'h1, RESP_OKAY);
        rdChk(IDX_CHIP_MODE, 32'h80);
        wrChk(8'h71, 32'hff, 4'h1, RESP_OKAY);
        rdChk(8'h71, 32'h0);
        wrChk(8'h40, 32'hff, 4'h1, RESP_SLVERR);
        axiRd(8'h40, rd, rs);
        cmpVal("unmappedResp", 32'(RESP_SLVERR), 32'(rs));
        cmpVal("unmappedData", 32'h0, rd);
        doReset(1'b1);
        cmpVal("modeSelect", 32'(MODE_NORMAL), 32'(modeSelect));
        wrChk(IDX_CHIP_MODE, 32'h0, 4'h1, RESP_OKAY);
        rdChk(IDX_CHIP_MODE, 32'h80);
        wrChk(IDX_IRQ_ENABLE, 32'h3, 4'h1, RESP_OKAY);
        cpuState <= '{1'b1, 1'b1, 1'b1, 24'h123456};
        for (int k = 1; k < 5; k++) begin
            req(0, PFLASH_FIRST, 4'(k), e, x, t0);
            cmpVal("pflashErr", 32'(k == 4), 32'(e));
            cmpVal("exception", 32'(k == 4), 32'(x));
        end
        rdChk(IDX_SOURCE_TARGET, {24'h0, INIT_CPU, TGT_PFLASH});
        rdChk(IDX_ACCESS_KIND, {24'h0, ACC_STORE, ERR_ILLEGAL});
        rdChk(IDX_USER_STATE, 32'h80);
        rdChk(IDX_INT_MASKS, 32'h50);
        rdChk(IDX_PC_HIGH, 32'h12);
        rdChk(IDX_PC_MID, 32'h34);
        rdChk(IDX_PC_LOW, 32'h56);
        rdChk(IDX_IRQ_STATUS, 32'h1);
        cmpVal("irq", 32'h1, 32'(irq));
        req(2, RAM_FIRST, ACC_LOAD, e, x, t0);
        cmpVal("adcLoadErr", 32'h1, 32'(e));
        cmpVal("adcExc", 32'h1, 32'(x));
        req(0, EEPROM_FIRST, ACC_STORE, e, x, t0);
        cmpVal("eepromStoreErr", 32'h1, 32'(e));
        req(0, 24'h200000, ACC_LOAD, e, x, t0);
        cmpVal("unmappedErr", 32'h1, 32'(e));
        cmpVal("unmappedExc", 32'h1, 32'(x));
        rdChk(IDX_SOURCE_TARGET, {24'h0, INIT_CPU, TGT_PFLASH});
        rdChk(IDX_PC_LOW, 32'h56);
        wrChk(IDX_IRQ_ENABLE, 32'h0, 4'h1, RESP_OKAY);
        repeat (2) @(negedge clock);
        cmpVal("irqMasked", 32'h0, 32'(irq));
        wrChk(IDX_SOURCE_TARGET, 32'(ERR_CLEAR_KEY), 4'h3, RESP_OKAY);
        rdChk(IDX_SOURCE_TARGET, 32'h0);
        rdChk(IDX_ACCESS_KIND, 32'h0);
        wrChk(IDX_IRQ_CLEAR, 32'h3, 4'h1, RESP_OKAY);
        rdChk(IDX_IRQ_STATUS, 32'h0);
        wrChk(IDX_IRQ_ENABLE, 32'h3, 4'h1, RESP_OKAY);
        failMask <= 4'h2;
        req(0, RAM_FIRST + 24'h234, ACC_LOAD, e, x, t0);
        cmpVal("eccGrantErr", 32'h0, 32'(e));
        failMask <= 4'h0;
        repeat (3) @(posedge clock);
        rdChk(IDX_SOURCE_TARGET, {24'h0, INIT_CPU, TGT_RAM});
        rdChk(IDX_ACCESS_KIND, {24'h0, ACC_LOAD, ERR_ECC});
        rdChk(IDX_IRQ_STATUS, 32'h3);
        cmpVal("irqEcc", 32'h1, 32'(irq));
        req(2, RAM_FIRST, ACC_STORE, e, x, t0);
        cmpVal("adcStoreErr", 32'h0, 32'(e));
        fork
            req(0, RAM_FIRST, ACC_LOAD, e, x, t0);
            req(1, RAM_FIRST, ACC_LOAD, e2, x2, t1);
        join
        cmpVal("debugFirst", 32'h1, 32'(t1 < t0));
        fork
            req(0, RAM_FIRST, ACC_LOAD, e, x, t0);
            req(1, 24'h000100, ACC_LOAD, e2, x2, t1);
        join
        cmpVal("parallel", 32'(t0), 32'(t1));
        stopMode <= 1'b1;
        fork
            req(0, RAM_FIRST, ACC_LOAD, e, x, t0);
            begin
                repeat (6) @(posedge clock);
                stopMode <= 1'b0;
            end
        join
        cmpVal("stopHeld", 32'h1, 32'(t0 > 6));
        end_sim();
    end
endmodule : mmap_memory_map_mode_control_tb_top

bind mmap_memory_map_mode_control mmap_assertions chkInst (.clock(clock), .rstn(rstn), .modePin(modePin),
    .stopMode(stopMode), .masterResp(masterResp), .machineException(machineException), .targetSel(targetSel),
    .eccError(eccError), .modeSelect(modeSelect), .rvalid(rvalid), .rresp(rresp), .rdata(rdata));
